// ==== verilog/ptb_consts.vh ====
// Purpose: shared constants for the pwm time-base block
// Assumes: included by the time-base design files and by the checker and bench files
// Notes: register indices are word indices; byte address is four times the index
`ifndef PTB_CONSTS_VH
`define PTB_CONSTS_VH

// register word indices
`define PTB_IDX_CONTROL 3'h0
`define PTB_IDX_STATUS 3'h1
`define PTB_IDX_FINE 3'h2
`define PTB_IDX_PHASE 3'h3
`define PTB_IDX_COUNTER 3'h4
`define PTB_IDX_PERIOD 3'h5
`define PTB_IDX_INT_STATUS 3'h6
`define PTB_IDX_INT_MASK 3'h7

// apb address layout
`define PTB_ADDR_W 12
`define PTB_IDX_LSB 2
`define PTB_IDX_MSB 4
`define PTB_ADDR_HI_LSB 5
`define PTB_ADDR_HI_ZERO 7'h00

// control word fields
`define PTB_CTL_MODE_LSB 0
`define PTB_CTL_MODE_MSB 1
`define PTB_CTL_PHASE_EN 2
`define PTB_CTL_PRD_LOAD 3
`define PTB_CTL_SYNCO_LSB 4
`define PTB_CTL_SYNCO_MSB 5
`define PTB_CTL_SW_SYNC 6
`define PTB_CTL_HSP_LSB 7
`define PTB_CTL_HSP_MSB 9
`define PTB_CTL_DIV_LSB 10
`define PTB_CTL_DIV_MSB 12
`define PTB_CTL_RW_MASK 16'h1fbf
`define PTB_CTL_RST 16'h0003

// status word fields
`define PTB_STS_DIR 0
`define PTB_STS_SYNC 1
`define PTB_STS_MAX 2

// interrupt status and mask fields
`define PTB_INT_ZERO 0
`define PTB_INT_PERIOD 1
`define PTB_INT_SYNC 2
`define PTB_INT_MAX 3
`define PTB_INT_W 4

// count modes
`define PTB_MODE_UP 2'h0
`define PTB_MODE_DOWN 2'h1
`define PTB_MODE_UPDOWN 2'h2
`define PTB_MODE_FREEZE 2'h3

// sync out sources
`define PTB_SYNCO_IN 2'h0
`define PTB_SYNCO_ZERO 2'h1
`define PTB_SYNCO_COMPARE_B_VALUE 2'h2
`define PTB_SYNCO_OFF 2'h3

// counter values and reset values
`define PTB_ZERO_MATCH_EVENT 16'h0000
`define PTB_COUNTER_AT_MAX 16'hffff
`define PTB_CTR_ONE 16'h0001
`define PTB_WORD_RST 16'h0000
`define PTB_DATA_RST 32'h00000000

// prescaler
`define PTB_DIV_W 11
`define PTB_DIV_ONE 11'h001

`endif

// ==== verilog/ptb_sync2.v ====
// Purpose: two flip-flop synchroniser for one level
// Assumes: input may come from a pin outside the core_clk domain
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ps
module ptb_sync2 (
   input wire core_clk, // system clock
   input wire reset, // async reset, active high
   input wire din, // raw asynchronous level
   output reg dout // synchronised level
);
   reg meta_r; // first stage, read only by dout

   // two stages, no logic between them
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_r <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule

// ==== verilog/ptb_prescale.v ====
// Purpose: derives the time-base tick from the system clock
// Assumes: divider fields are stable or change only between ticks
// Notes: divisor is high-speed factor times a power of two
`timescale 1ns/1ps
`include "ptb_consts.vh"
module ptb_prescale (
   input wire core_clk, // system clock
   input wire reset, // async reset, active high
   input wire [2:0] high_speed_prescale, // 0 gives 1, n gives 2n
   input wire [2:0] tick_prescale, // divide by 2 to the n
   output reg timebase_tick // one-cycle tick pulse
);
   reg [`PTB_DIV_W-1:0] cnt_r; // cycles since last tick
   wire [`PTB_DIV_W-1:0] hsp_div; // high-speed factor
   wire [`PTB_DIV_W-1:0] total_div; // full divisor

   assign hsp_div = (high_speed_prescale == 3'h0) ? `PTB_DIV_ONE : {7'h00, high_speed_prescale, 1'b0};
   assign total_div = hsp_div << tick_prescale;

   // free-running divider; >= guards against a divisor shrunk mid-count
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_r <= {`PTB_DIV_W{1'b0}};
         timebase_tick <= 1'b0;
      end
      else if (cnt_r + `PTB_DIV_ONE >= total_div)
      begin
         cnt_r <= {`PTB_DIV_W{1'b0}};
         timebase_tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + `PTB_DIV_ONE;
         timebase_tick <= 1'b0;
      end
   end
endmodule

// ==== verilog/ptb_timebase.v ====
// Purpose: pwm time-base counter with sync chaining and apb registers
// Assumes: compare_b_match_event comes from same-clock logic; sync_in_pulse may come from a pin
// Notes: registers sit at byte address four times their word index
//
// What this block does
// - eight registers at word indices zero to seven
// - fine phase word reserved when extension absent
// - accept sync input, configurable use or ignore
// - chain: pin feeds first, sync out feeds next
// - sync out from input, zero or compare-B
// - period match uses active period, not shadow
// - zero match whenever counter is zero
// - period double-buffered, other registers written directly
// - up, down and up-down count modes
// - direction high counting up, low down
// - counter all ones flagged as status bit
// - counter advances only on prescaled tick
`timescale 1ns/1ps
`include "ptb_consts.vh"
module ptb_timebase #(
   parameter FINE_EXT = 0 // 1 when the fine-resolution extension is built in
) (
   input wire core_clk, // system clock, 40 MHz
   input wire reset, // async reset, active high
   input wire psel, // apb select
   input wire penable, // apb access phase
   input wire pwrite, // apb direction, high for write
   input wire [`PTB_ADDR_W-1:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error, unmapped address
   input wire sync_in_pulse, // sync from earlier module or pin
   input wire compare_b_match_event, // counter equals compare-B
   output reg sync_out_pulse, // sync to later module
   output reg zero_match_event, // counter equals zero
   output reg period_match_event, // counter equals active period
   output reg count_direction, // high counting up
   output reg timebase_tick, // shared prescaled tick
   output reg [15:0] counter_value, // live counter
   output reg irq // level interrupt
);
   // register state
   reg [15:0] control_r; // control word
   reg [15:0] phase_r; // phase offset
   reg [15:0] fine_r; // fine phase extension
   reg [15:0] period_act_r; // active period
   reg [15:0] period_shd_r; // shadow period
   reg sts_sync_r; // sticky: sync input seen
   reg sts_max_r; // sticky: counter hit all ones
   reg [`PTB_INT_W-1:0] int_sts_r; // sticky event bits
   reg [`PTB_INT_W-1:0] int_mask_r; // interrupt enables
   reg [15:0] ctr_r; // counter
   reg dir_r; // count direction
   reg sync_d_r; // previous synchronised sync level
   reg compare_b_value_d_r; // previous compare-B level

   // next values
   reg [15:0] ctr_nxt; // counter next
   reg dir_nxt; // direction next
   reg [31:0] rdata_nxt; // read mux

   wire sync_lvl; // synchronised sync input
   wire tick; // prescaled tick
   wire [1:0] mode; // count mode
   wire [1:0] synco_sel; // sync out source
   wire phase_en; // phase load enable
   wire prd_immediate; // period written straight to active
   wire [2:0] idx; // register word index
   wire mapped; // address decodes
   wire setup; // apb setup cycle
   wire wr_en; // write takes effect
   wire [15:0] wdat; // low half of write data
   wire sync_rise; // incoming sync pulse edge
   wire sw_sync; // software forced sync
   wire sync_evt; // any sync event
   wire compare_b_value_rise; // compare-B edge
   wire at_zero; // counter is zero
   wire at_prd; // counter equals active period
   wire at_max; // counter all ones
   wire [`PTB_INT_W-1:0] int_set; // event set terms
   wire [`PTB_INT_W-1:0] int_clr; // write-one-to-clear terms

   assign mode = control_r[`PTB_CTL_MODE_MSB:`PTB_CTL_MODE_LSB];
   assign synco_sel = control_r[`PTB_CTL_SYNCO_MSB:`PTB_CTL_SYNCO_LSB];
   assign phase_en = control_r[`PTB_CTL_PHASE_EN];
   assign prd_immediate = control_r[`PTB_CTL_PRD_LOAD];
   assign idx = paddr[`PTB_IDX_MSB:`PTB_IDX_LSB];
   assign mapped = (paddr[`PTB_ADDR_W-1:`PTB_ADDR_HI_LSB] == `PTB_ADDR_HI_ZERO) && (paddr[1:0] == 2'h0);
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && mapped;
   assign wdat = pwdata[15:0];

   // first module takes this from a pin, later ones from the previous sync out, so always synchronise
   ptb_sync2 u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .din(sync_in_pulse),
      .dout(sync_lvl)
   );

   ptb_prescale u_pre (
      .core_clk(core_clk),
      .reset(reset),
      .high_speed_prescale(control_r[`PTB_CTL_HSP_MSB:`PTB_CTL_HSP_LSB]),
      .tick_prescale(control_r[`PTB_CTL_DIV_MSB:`PTB_CTL_DIV_LSB]),
      .timebase_tick(tick)
   );

   // event decode
   assign sync_rise = sync_lvl && !sync_d_r;
   assign sw_sync = wr_en && (idx == `PTB_IDX_CONTROL) && wdat[`PTB_CTL_SW_SYNC];
   assign sync_evt = sync_rise || sw_sync;
   assign compare_b_value_rise = compare_b_match_event && !compare_b_value_d_r;
   assign at_zero = (ctr_r == `PTB_ZERO_MATCH_EVENT);
   assign at_prd = (ctr_r == period_act_r);
   assign at_max = (ctr_r == `PTB_COUNTER_AT_MAX);

   // counter step; sync load and software writes take priority over the tick
   always @*
   begin
      ctr_nxt = ctr_r;
      dir_nxt = dir_r;
      if (wr_en && (idx == `PTB_IDX_COUNTER))
      begin
         ctr_nxt = wdat; // direct write, no shadow
      end
      else if (sync_evt && phase_en)
      begin
         ctr_nxt = phase_r;
      end
      else if (tick)
      begin
         case (mode)
            `PTB_MODE_UP:
            begin
               dir_nxt = 1'b1;
               ctr_nxt = (ctr_r >= period_act_r) ? `PTB_ZERO_MATCH_EVENT : ctr_r + `PTB_CTR_ONE;
            end
            `PTB_MODE_DOWN:
            begin
               dir_nxt = 1'b0;
               ctr_nxt = at_zero ? period_act_r : ctr_r - `PTB_CTR_ONE;
            end
            `PTB_MODE_UPDOWN:
            begin
               if (dir_r && (ctr_r >= period_act_r))
               begin
                  dir_nxt = 1'b0; // turn at period
                  ctr_nxt = ctr_r - `PTB_CTR_ONE;
               end
               else if (!dir_r && at_zero)
               begin
                  dir_nxt = 1'b1; // turn at zero
                  ctr_nxt = ctr_r + `PTB_CTR_ONE;
               end
               else
               begin
                  ctr_nxt = dir_r ? ctr_r + `PTB_CTR_ONE : ctr_r - `PTB_CTR_ONE;
               end
            end
            default:
            begin
               ctr_nxt = ctr_r; // freeze
            end
         endcase
      end
   end

   // counter, direction and edge history
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         ctr_r <= `PTB_ZERO_MATCH_EVENT;
         dir_r <= 1'b1;
         sync_d_r <= 1'b0;
         compare_b_value_d_r <= 1'b0;
      end
      else
      begin
         ctr_r <= ctr_nxt;
         dir_r <= dir_nxt;
         sync_d_r <= sync_lvl;
         compare_b_value_d_r <= compare_b_match_event;
      end
   end

   // control, phase and fine words are written directly
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         control_r <= `PTB_CTL_RST;
         phase_r <= `PTB_WORD_RST;
         fine_r <= `PTB_WORD_RST;
      end
      else if (wr_en)
      begin
         if (idx == `PTB_IDX_CONTROL)
         begin
            control_r <= wdat & `PTB_CTL_RW_MASK; // forced sync bit is not stored
         end
         if (idx == `PTB_IDX_PHASE)
         begin
            phase_r <= wdat;
         end
         if ((idx == `PTB_IDX_FINE) && (FINE_EXT != 0))
         begin
            fine_r <= wdat;
         end
      end
   end

   // period: shadow copy moves to active when the counter reaches zero on a tick
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         period_act_r <= `PTB_WORD_RST;
         period_shd_r <= `PTB_WORD_RST;
      end
      else if (wr_en && (idx == `PTB_IDX_PERIOD))
      begin
         if (prd_immediate)
         begin
            period_act_r <= wdat; // immediate mode bypasses the shadow
         end
         else
         begin
            period_shd_r <= wdat;
         end
      end
      else if (!prd_immediate && tick && at_zero)
      begin
         period_act_r <= period_shd_r;
      end
   end

   // sticky flags: a set in the same cycle as a clear wins
   assign int_set[`PTB_INT_ZERO] = tick && at_zero;
   assign int_set[`PTB_INT_PERIOD] = tick && at_prd;
   assign int_set[`PTB_INT_SYNC] = sync_rise;
   assign int_set[`PTB_INT_MAX] = at_max;
   assign int_clr = (wr_en && (idx == `PTB_IDX_INT_STATUS)) ? wdat[`PTB_INT_W-1:0] : {`PTB_INT_W{1'b0}};

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         int_sts_r <= {`PTB_INT_W{1'b0}};
         int_mask_r <= {`PTB_INT_W{1'b0}};
         sts_sync_r <= 1'b0;
         sts_max_r <= 1'b0;
      end
      else
      begin
         int_sts_r <= (int_sts_r & ~int_clr) | int_set;
         if (wr_en && (idx == `PTB_IDX_INT_MASK))
         begin
            int_mask_r <= wdat[`PTB_INT_W-1:0];
         end
         if (wr_en && (idx == `PTB_IDX_STATUS))
         begin
            sts_sync_r <= sync_rise || (sts_sync_r && !wdat[`PTB_STS_SYNC]);
            sts_max_r <= at_max || (sts_max_r && !wdat[`PTB_STS_MAX]);
         end
         else
         begin
            sts_sync_r <= sts_sync_r || sync_rise;
            sts_max_r <= sts_max_r || at_max;
         end
      end
   end

   // read mux; reserved words and bits read zero
   always @*
   begin
      rdata_nxt = `PTB_DATA_RST;
      case (idx)
         `PTB_IDX_CONTROL: rdata_nxt[15:0] = control_r;
         `PTB_IDX_STATUS:
         begin
            rdata_nxt[`PTB_STS_DIR] = dir_r;
            rdata_nxt[`PTB_STS_SYNC] = sts_sync_r;
            rdata_nxt[`PTB_STS_MAX] = sts_max_r;
         end
         `PTB_IDX_FINE: rdata_nxt[15:0] = (FINE_EXT != 0) ? fine_r : `PTB_WORD_RST;
         `PTB_IDX_PHASE: rdata_nxt[15:0] = phase_r;
         `PTB_IDX_COUNTER: rdata_nxt[15:0] = ctr_r;
         `PTB_IDX_PERIOD: rdata_nxt[15:0] = prd_immediate ? period_act_r : period_shd_r;
         `PTB_IDX_INT_STATUS: rdata_nxt[`PTB_INT_W-1:0] = int_sts_r;
         `PTB_IDX_INT_MASK: rdata_nxt[`PTB_INT_W-1:0] = int_mask_r;
         default: rdata_nxt = `PTB_DATA_RST;
      endcase
   end

   // apb slave: ready rises one cycle after setup, so every transfer has one wait-free access cycle
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         prdata <= `PTB_DATA_RST;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite)
         begin
            prdata <= mapped ? rdata_nxt : `PTB_DATA_RST;
         end
      end
   end

   // registered outputs to the other submodules and the next module in the chain
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         sync_out_pulse <= 1'b0;
         zero_match_event <= 1'b0;
         period_match_event <= 1'b0;
         count_direction <= 1'b1;
         timebase_tick <= 1'b0;
         counter_value <= `PTB_ZERO_MATCH_EVENT;
         irq <= 1'b0;
      end
      else
      begin
         case (synco_sel)
            `PTB_SYNCO_IN: sync_out_pulse <= sync_evt;
            `PTB_SYNCO_ZERO: sync_out_pulse <= tick && at_zero;
            `PTB_SYNCO_COMPARE_B_VALUE: sync_out_pulse <= compare_b_value_rise;
            default: sync_out_pulse <= 1'b0;
         endcase
         zero_match_event <= (ctr_nxt == `PTB_ZERO_MATCH_EVENT);
         period_match_event <= (ctr_nxt == period_act_r);
         count_direction <= dir_nxt;
         timebase_tick <= tick;
         counter_value <= ctr_nxt;
         irq <= |(((int_sts_r & ~int_clr) | int_set) & int_mask_r);
      end
   end
endmodule

// ==== dv/ptb_chain_model.sv ====
// Purpose: earlier chain stage and compare-B source facing the time-base block
// Assumes: same clock as the block
// Notes: sync pulse lasts two cycles so the block's input synchroniser cannot miss it
`timescale 1ns/1ps
module ptb_chain_model (
   input wire logic core_clk, // system clock
   input wire logic reset, // async reset, active high
   input wire logic fire, // request one sync pulse
   input wire logic [15:0] counter_value, // live counter of the block
   input wire logic [15:0] compare_b_value_value, // compare-B value
   output logic sync_in_pulse, // sync into the block
   output logic compare_b_match_event // counter equals compare-B
);
   logic [1:0] width_r; // pulse cycles left
   // earlier stage's sync out drives this block's sync in
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
         width_r <= 2'h0;
      else if (fire)
         width_r <= 2'h2;
      else if (width_r != 2'h0)
         width_r <= width_r - 2'h1;
   end
   assign sync_in_pulse = (width_r != 2'h0);
   // level match, as a compare stage would give it
   assign compare_b_match_event = (counter_value == compare_b_value_value);
endmodule

// ==== dv/ptb_timebase_checker.sv ====
// Purpose: port-level assertions for the time-base block
// Assumes: one clock domain, async active-high reset
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
`include "ptb_consts.vh"
module ptb_timebase_checker #(
   parameter FINE_EXT = 0 // fine extension built in
) (
   input wire core_clk, // system clock
   input wire reset, // async reset
   input wire psel, // apb select
   input wire penable, // apb access
   input wire pwrite, // apb direction
   input wire [`PTB_ADDR_W-1:0] paddr, // apb address
   input wire [31:0] prdata, // apb read data
   input wire pready, // apb ready
   input wire pslverr, // apb error
   input wire sync_out_pulse, // sync to next stage
   input wire zero_match_event, // counter zero
   input wire count_direction, // high counting up
   input wire [15:0] counter_value, // live counter
   input wire irq // level interrupt
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   wire setup = psel && !penable; // setup cycle
   wire wr_acc = psel && penable && pwrite; // write access cycle
   wire bad = (paddr[11:5] != 7'h00) || (paddr[1:0] != 2'h0); // unmapped address
   property p_zero_level;
      !$past(reset) |-> zero_match_event == (counter_value == 16'h0000);
   endproperty
   a_zero_level: assert property (p_zero_level) else $error("zero level wrong");
   // mid-range increments only; the turning points are left open
   property p_dir_up;
      (counter_value == $past(counter_value) + 16'h0001) && ($past(counter_value) != 16'h0000)
         && !$past(wr_acc) && !$past(wr_acc, 2) |-> $past(count_direction);
   endproperty
   a_dir_up: assert property (p_dir_up) else $error("direction low while counting up");
   property p_ready_once;
      setup |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready not one cycle");
   property p_err_bad;
      setup && bad |=> pslverr && pready;
   endproperty
   a_err_bad: assert property (p_err_bad) else $error("no error on unmapped address");
   property p_err_ok;
      setup && !bad |=> !pslverr;
   endproperty
   a_err_ok: assert property (p_err_ok) else $error("error on mapped address");
   property p_bad_zero;
      setup && !pwrite && bad |=> prdata == 32'h00000000;
   endproperty
   a_bad_zero: assert property (p_bad_zero) else $error("unmapped read not zero");
   property p_fine_rsvd;
      setup && !pwrite && (paddr == 12'h008) && (FINE_EXT == 0) |=> prdata == 32'h00000000;
   endproperty
   a_fine_rsvd: assert property (p_fine_rsvd) else $error("reserved word not zero");
   property p_rd_hold;
      !(setup && !pwrite) |=> $stable(prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_sync_single;
      sync_out_pulse |=> !sync_out_pulse;
   endproperty
   a_sync_single: assert property (p_sync_single) else $error("sync out too long");
   c_sync: cover property (sync_out_pulse);
   c_err: cover property (pslverr);
   c_irq: cover property ($rose(irq));
endmodule
bind ptb_timebase ptb_timebase_checker #(.FINE_EXT(FINE_EXT)) ptb_timebase_checker_inst (.core_clk(core_clk),
   .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sync_out_pulse(sync_out_pulse), .zero_match_event(zero_match_event),
   .count_direction(count_direction), .counter_value(counter_value), .irq(irq));

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the time-base block
// Assumes: 40 MHz clock, apb master with one-cycle idle between transfers
// Notes: divider fields stay at zero, dividing by one, except in the tick test
`timescale 1ns/1ps
`include "ptb_consts.vh"
module tb;
   logic core_clk = 1'b0; // system clock
   logic reset = 1'b1; // async reset
   logic psel = 1'b0; // apb select
   logic penable = 1'b0; // apb access
   logic pwrite = 1'b0; // apb direction
   logic [11:0] paddr = 12'h000; // apb address
   logic [31:0] pwdata = 32'h00000000; // apb write data
   logic fire = 1'b0; // ask model for a sync pulse
   logic [15:0] compare_b_value = 16'h0005; // compare-B value
   wire [31:0] prdata; // apb read data
   wire pready, pslverr, sync_in, compare_b_value_hit, sync_out, zero_hit, prd_hit, dir, tick, irq; // block pins
   wire [15:0] ctr; // live counter
   int fails = 0; // mismatches
   int comparisons = 0; // checks made
   int i, n, m; // loop counters
   logic [15:0] q, per, ph, prev; // read data, period, phase, last counter
   logic e, up; // error flag, tracked direction
   ptb_timebase #(.FINE_EXT(0)) ptb_timebase_inst (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_in_pulse(sync_in), .compare_b_match_event(compare_b_value_hit), .sync_out_pulse(sync_out),
      .zero_match_event(zero_hit), .period_match_event(prd_hit), .count_direction(dir), .timebase_tick(tick),
      .counter_value(ctr), .irq(irq));
   // earlier chain stage feeds the sync input
   ptb_chain_model ptb_chain_model_inst (.core_clk(core_clk), .reset(reset), .fire(fire),
      .counter_value(ctr), .compare_b_value_value(compare_b_value), .sync_in_pulse(sync_in), .compare_b_match_event(compare_b_value_hit));
   // clock at 25 ns
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   function logic [11:0] ad(input logic [2:0] idx);
      return {7'h00, idx, 2'h0};
   endfunction
   // expected next counter value for a mode
   function logic [15:0] nxt(input int md, input logic [15:0] p, input logic u);
      if (md == 0) return (p == per) ? 16'h0000 : p + 16'h0001;
      if (md == 1) return (p == 16'h0000) ? per : p - 16'h0001;
      if (p == 16'h0000 || (u && p != per)) return p + 16'h0001;
      return p - 16'h0001;
   endfunction
   task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
      comparisons++;
      if (g !== x)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask
   // one apb transfer, held until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata[15:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function logic pick(input int k);
      case (k)
         0: return prd_hit;
         1: return sync_out;
         2: return ctr == 16'h0001;
         default: return tick;
      endcase
   endfunction
   // bounded wait for an event
   task wait_ev(input int k);
      int t;
      t = 0;
      do begin @(posedge core_clk); t++; end while (pick(k) !== 1'b1 && t < 3000);
      chk("event wait", 16'h0001, {15'h0000, t < 3000});
   endtask
   task fire_sync;
      @(posedge core_clk);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
   endtask
   task give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (30000) @(posedge core_clk);
      fails++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      give_verdict;
   end
   initial
   begin
      void'($urandom(32'h71ce));
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      apb(0, ad(`PTB_IDX_CONTROL), 0); chk("control reset", `PTB_CTL_RST, q);
      apb(1, ad(`PTB_IDX_FINE), 16'h1234); apb(0, ad(`PTB_IDX_FINE), 0); chk("fine rsvd", 16'h0, q);
      apb(0, 12'h020, 0); chk("unmapped", 16'h0001, {15'h0, e});
      $display("test map done");
      per = 16'h000c + 16'($urandom % 8);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h000b);
      apb(1, ad(`PTB_IDX_PERIOD), per);
      apb(0, ad(`PTB_IDX_PERIOD), 0); chk("period direct", per, q);
      for (m = 0; m < 3; m++)
      begin
         apb(1, ad(`PTB_IDX_CONTROL), 16'h0008 | 16'(m));
         repeat (3) @(posedge core_clk);
         prev = ctr;
         n = 0;
         up = 1'b0;
         for (i = 0; i < 4 * per + 8; i++)
         begin
            @(posedge core_clk);
            chk("period match", {15'h0, ctr == per}, {15'h0, prd_hit});
            chk("zero match", {15'h0, ctr == 16'h0}, {15'h0, zero_hit});
            if (ctr !== prev)
            begin
               if (m != 2 || n > 0) chk("count step", nxt(m, prev, up), ctr);
               up = ctr > prev;
               n++;
               prev = ctr;
            end
            if (ctr != 16'h0 && ctr != per && n > 0)
               chk("direction", {15'h0, m == 2 ? up : m == 0}, {15'h0, dir});
         end
      end
      $display("test modes done");
      apb(1, ad(`PTB_IDX_COUNTER), 16'h0005);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0000);
      apb(1, ad(`PTB_IDX_PERIOD), per);
      wait_ev(2);
      apb(1, ad(`PTB_IDX_PERIOD), per + 16'h0003);
      wait_ev(0); chk("active period", per, ctr);
      apb(0, ad(`PTB_IDX_PERIOD), 0); chk("shadow read", per + 16'h0003, q);
      wait_ev(0); chk("shadow moved", per + 16'h0003, ctr);
      $display("test shadow done");
      ph = 16'h0100 + 16'($urandom % 16'h0e00);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0007);
      apb(1, ad(`PTB_IDX_PHASE), ph);
      fire_sync; wait_ev(1); chk("phase load", ph, ctr);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0003);
      apb(1, ad(`PTB_IDX_COUNTER), 16'h0007);
      fire_sync; wait_ev(1); chk("sync ignored", 16'h0007, ctr);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0007);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0047);
      repeat (3) @(posedge core_clk); chk("soft sync", ph, ctr);
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0028);
      wait_ev(1); chk("compare_b_value source", 16'h0001, {15'h0, ctr >= compare_b_value && ctr <= compare_b_value + 16'h2});
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0018);
      wait_ev(1); chk("zero source", 16'h0001, {15'h0, ctr <= 16'h0001});
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0038);
      n = 0;
      repeat (3 * per) begin @(posedge core_clk); n += sync_out; end
      chk("sync off", 16'h0, 16'(n));
      $display("test sync done");
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0488);
      repeat (8) @(posedge core_clk);
      wait_ev(3);
      n = 0;
      do begin @(posedge core_clk); n++; end while (tick !== 1'b1 && n < 50);
      chk("tick spacing", 16'h0004, 16'(n));
      $display("test tick done");
      apb(1, ad(`PTB_IDX_CONTROL), 16'h0003);
      apb(1, ad(`PTB_IDX_COUNTER), 16'h0005);
      apb(1, ad(`PTB_IDX_INT_STATUS), 16'h000f);
      apb(0, ad(`PTB_IDX_INT_STATUS), 0); chk("int cleared", 16'h0, q);
      apb(1, ad(`PTB_IDX_INT_MASK), 16'h0004);
      fire_sync;
      repeat (6) @(posedge core_clk); chk("irq raised", 16'h1, {15'h0, irq});
      apb(1, ad(`PTB_IDX_INT_MASK), 16'h0000);
      repeat (2) @(posedge core_clk); chk("irq masked", 16'h0, {15'h0, irq});
      apb(1, ad(`PTB_IDX_INT_MASK), 16'h0004);
      repeat (2) @(posedge core_clk); chk("irq unmasked", 16'h1, {15'h0, irq});
      apb(1, ad(`PTB_IDX_INT_STATUS), 16'h0004);
      repeat (2) @(posedge core_clk); chk("irq cleared", 16'h0, {15'h0, irq});
      apb(1, ad(`PTB_IDX_COUNTER), `PTB_COUNTER_AT_MAX);
      apb(0, ad(`PTB_IDX_STATUS), 0); chk("max flag", 16'h0004, q & 16'h0004);
      apb(1, ad(`PTB_IDX_COUNTER), 16'h0005);
      apb(1, ad(`PTB_IDX_STATUS), 16'h0004);
      apb(0, ad(`PTB_IDX_STATUS), 0); chk("max cleared", 16'h0, q & 16'h0004);
      $display("test status done");
      give_verdict;
   end
endmodule
